//--- shared/shift_logic_cfg.svh
// Opcode patterns, addressing-byte field values and clock counts for the shift/rotate/logic decoder
// Assumes inclusion by bare name from the package and design files
`ifndef SHIFT_LOGIC_CFG_SVH
`define SHIFT_LOGIC_CFG_SVH

// Opcode prefixes (w bit excluded, d and w for register AND); escape and second bytes in full
`define OPC_ESCAPE        8'h0F
`define OPC_SHIFT_ONE     7'h68
`define OPC_SHIFT_CNT     7'h69
`define OPC_SHIFT_IMM     7'h60
`define OPC_AND_RR        6'h08
`define OPC_AND_RM        7'h10
`define OPC_AND_MR        7'h11
`define OPC_GRP_IMM       7'h40
`define OPC_AND_ACC       7'h12
`define OPC_TEST_RM       7'h42
`define OPC_GRP_UNARY     7'h7B
`define OPC2_DSHL_IMM     8'hA4
`define OPC2_DSHL_CNT     8'hA5
`define OPC2_DSHR_IMM     8'hAC
`define OPC2_DSHR_CNT     8'hAD

// Addressing-byte reg and mod field values
`define REG_AND_IMM       3'h4
`define REG_TEST_IMM      3'h0
`define MOD_REGISTER      2'h3

// Clock counts
`define CLK_SHIFT_REG     4'h3
`define CLK_SHIFT_MEM     4'h7
`define CLK_RC_REG        4'h9
`define CLK_RC_MEM        4'hA
`define CLK_AND_RR        4'h2
`define CLK_AND_RM        4'h7
`define CLK_AND_MR        4'h6
`define CLK_IMM_REG       4'h2
`define CLK_IMM_MEM       4'h7
`define CLK_TEST_REG      4'h2
`define CLK_TEST_MEM      4'h5

`endif

//--- shared/shift_logic_pkg.sv
// Types for the shift/rotate/logic decoder
// Assumes shift_logic_cfg.svh is on the include path
`include "shift_logic_cfg.svh"
package shift_logic_pkg;

  typedef enum logic [2:0] {
    ROTATE_LEFT             = 3'h0,
    ROTATE_RIGHT            = 3'h1,
    ROTATE_LEFT_THRU_CARRY  = 3'h2,
    ROTATE_RIGHT_THRU_CARRY = 3'h3,
    SHIFT_LEFT              = 3'h4,
    LOGICAL_RIGHT_SHIFT     = 3'h5,
    SHIFT_OP_RESERVED       = 3'h6,
    ARITH_RIGHT_SHIFT       = 3'h7
  } shift_op_type;

  typedef enum logic [3:0] {
    OP_NONE         = 4'h0,
    OP_SHIFT        = 4'h1,
    OP_DOUBLE_LEFT  = 4'h2,
    OP_DOUBLE_RIGHT = 4'h3,
    OP_AND          = 4'h4,
    OP_TEST         = 4'h5
  } op_class_type;

  typedef enum logic [1:0] {
    CNT_ONE   = 2'h0,
    CNT_REG   = 2'h1,
    CNT_IMM   = 2'h2
  } count_src_type;

endpackage

//--- logic/clock_counter.sv
// Countdown timer that holds busy for a loaded number of clocks
// Assumes a single clock; load is ignored while busy
`timescale 1ns/10ps
module clock_counter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic [3:0] count_i,
  output logic            busy_o,
  output logic            done_o
);

  logic [3:0] remain_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      remain_q <= 4'h0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (remain_q != 4'h0) begin
        remain_q <= remain_q - 4'h1;
        if (remain_q == 4'h1) begin
          done_o <= 1'b1;
        end
      end else if (load_i) begin
        remain_q <= count_i;
      end
    end
  end

  assign busy_o = (remain_q != 4'h0);

endmodule

//--- logic/shift_rotate_logic_decode.sv
// Decoder and clock-count timer for shift, rotate, double shift, AND and test
// Assumes one instruction presented per accepted strobe, bytes already fetched
// What this block does
// [RQ1] Op field 0-3 rotates, 4 left shift, 5 logical right, 7 arithmetic right.
// [RQ2] 1101001w with addressing byte: shift by count register, 3/7 clocks.
// [RQ3] 1100000w with addressing byte and immediate: shift by immediate, 3/7 clocks.
// [RQ4] Rotates through carry take 9 clocks on register, 10 on memory.
// [RQ5] 0F A4 immediate, 0F A5 count register: double left shift, 3/7 clocks.
// [RQ6] 0F AC immediate, 0F AD count register: double right shift, 3/7 clocks.
// [RQ7] 001000dw register to register AND, 2 clocks.
// [RQ8] 0010000w AND into memory from register, 7 clocks.
// [RQ9] 0010001w AND into register from memory, 6 clocks.
// [RQ10] 1000000w reg 100 with immediate: AND immediate, 2/7 clocks.
// [RQ11] 0010010w immediate AND into accumulator, no addressing byte, 2 clocks.
// [RQ12] 1000010w test register with register/memory, flags only, 2/5 clocks.
// [RQ13] 1111011w reg 000 with immediate: test flags only, 2/5 clocks.
// [RQ14] Low opcode bit w: zero byte operand, one full width.
// [RQ15] Direction bit d: one means reg field is destination.
`timescale 1ns/10ps
`include "shift_logic_cfg.svh"
module shift_rotate_logic_decode (
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       INSN_VALID_I,
  input  wire logic [7:0] OPCODE0_I,
  input  wire logic [7:0] OPCODE1_I,
  input  wire logic [7:0] MODRM_I,
  input  wire logic [7:0] IMM8_I,
  output logic            READY_O,
  output logic            DECODE_VALID_O,
  output logic            ILLEGAL_O,
  output logic [3:0]      OP_CLASS_O,
  output logic [2:0]      SHIFT_OP_O,
  output logic [1:0]      COUNT_SRC_O,
  output logic [7:0]      IMM_COUNT_O,
  output logic            FULL_WIDTH_O,
  output logic            REG_IS_DEST_O,
  output logic            MEM_OPERAND_O,
  output logic            ACCUM_DEST_O,
  output logic            FLAGS_ONLY_O,
  output logic            HAS_MODRM_O,
  output logic            HAS_IMM_O,
  output logic [3:0]      CLOCKS_O,
  output logic            DONE_O
);

  // ------------------------------------------------------------
  // Combinational decode
  // ------------------------------------------------------------
  shift_logic_pkg::op_class_type  cls_d;
  shift_logic_pkg::count_src_type cnt_d;
  shift_logic_pkg::shift_op_type  sop_d;
  logic [3:0]                     clk_d;
  logic                           mem_d;
  logic                           illegal_d;
  logic                           reg_dest_d;
  logic                           acc_d;
  logic                           flags_d;
  logic                           modrm_d;
  logic                           imm_d;
  logic                           busy;
  logic                           tmr_done;
  logic                           take;

  assign take = INSN_VALID_I && !busy && !DECODE_VALID_O;

  always_comb begin
    cls_d      = shift_logic_pkg::OP_NONE;
    cnt_d      = shift_logic_pkg::CNT_ONE;
    sop_d      = shift_logic_pkg::shift_op_type'(MODRM_I[5:3]); // see [RQ1]
    mem_d      = (MODRM_I[7:6] != `MOD_REGISTER);
    clk_d      = 4'h0;
    illegal_d  = 1'b0;
    reg_dest_d = 1'b0;
    acc_d      = 1'b0;
    flags_d    = 1'b0;
    modrm_d    = 1'b1;
    imm_d      = 1'b0;
    if (OPCODE0_I == `OPC_ESCAPE) begin
      case (OPCODE1_I)
        `OPC2_DSHL_IMM, `OPC2_DSHL_CNT: begin // see [RQ5]
          cls_d = shift_logic_pkg::OP_DOUBLE_LEFT;
        end
        `OPC2_DSHR_IMM, `OPC2_DSHR_CNT: begin // see [RQ6]
          cls_d = shift_logic_pkg::OP_DOUBLE_RIGHT;
        end
        default: begin
          illegal_d = 1'b1;
        end
      endcase
      if (!illegal_d) begin
        imm_d = !OPCODE1_I[0];
        cnt_d = OPCODE1_I[0] ? shift_logic_pkg::CNT_REG : shift_logic_pkg::CNT_IMM;
        clk_d = mem_d ? `CLK_SHIFT_MEM : `CLK_SHIFT_REG; // see [RQ5] see [RQ6]
      end
    end else if (OPCODE0_I[7:1] == `OPC_SHIFT_ONE || OPCODE0_I[7:1] == `OPC_SHIFT_CNT ||
                 OPCODE0_I[7:1] == `OPC_SHIFT_IMM) begin
      cls_d = shift_logic_pkg::OP_SHIFT;
      if (OPCODE0_I[7:1] == `OPC_SHIFT_CNT) begin
        cnt_d = shift_logic_pkg::CNT_REG; // see [RQ2]
      end else if (OPCODE0_I[7:1] == `OPC_SHIFT_IMM) begin
        cnt_d = shift_logic_pkg::CNT_IMM; // see [RQ3]
        imm_d = 1'b1;
      end
      case (sop_d)
        shift_logic_pkg::ROTATE_LEFT_THRU_CARRY,
        shift_logic_pkg::ROTATE_RIGHT_THRU_CARRY: begin
          clk_d = mem_d ? `CLK_RC_MEM : `CLK_RC_REG; // see [RQ4]
        end
        shift_logic_pkg::SHIFT_OP_RESERVED: begin
          illegal_d = 1'b1;
        end
        default: begin
          clk_d = mem_d ? `CLK_SHIFT_MEM : `CLK_SHIFT_REG; // see [RQ2] see [RQ3]
        end
      endcase
    end else if (OPCODE0_I[7:2] == `OPC_AND_RR && !mem_d) begin
      cls_d      = shift_logic_pkg::OP_AND; // see [RQ7]
      reg_dest_d = OPCODE0_I[1]; // see [RQ15]
      clk_d      = `CLK_AND_RR;
    end else if (OPCODE0_I[7:1] == `OPC_AND_RM) begin
      cls_d = shift_logic_pkg::OP_AND; // see [RQ8]
      clk_d = `CLK_AND_RM;
    end else if (OPCODE0_I[7:1] == `OPC_AND_MR) begin
      cls_d      = shift_logic_pkg::OP_AND; // see [RQ9]
      reg_dest_d = 1'b1;
      clk_d      = `CLK_AND_MR;
    end else if (OPCODE0_I[7:1] == `OPC_GRP_IMM && MODRM_I[5:3] == `REG_AND_IMM) begin
      cls_d = shift_logic_pkg::OP_AND; // see [RQ10]
      imm_d = 1'b1;
      clk_d = mem_d ? `CLK_IMM_MEM : `CLK_IMM_REG;
    end else if (OPCODE0_I[7:1] == `OPC_AND_ACC) begin
      cls_d   = shift_logic_pkg::OP_AND; // see [RQ11]
      acc_d   = 1'b1;
      modrm_d = 1'b0;
      imm_d   = 1'b1;
      mem_d   = 1'b0;
      clk_d   = `CLK_AND_RR;
    end else if (OPCODE0_I[7:1] == `OPC_TEST_RM) begin
      cls_d   = shift_logic_pkg::OP_TEST; // see [RQ12]
      flags_d = 1'b1;
      clk_d   = mem_d ? `CLK_TEST_MEM : `CLK_TEST_REG;
    end else if (OPCODE0_I[7:1] == `OPC_GRP_UNARY && MODRM_I[5:3] == `REG_TEST_IMM) begin
      cls_d   = shift_logic_pkg::OP_TEST; // see [RQ13]
      flags_d = 1'b1;
      imm_d   = 1'b1;
      clk_d   = mem_d ? `CLK_TEST_MEM : `CLK_TEST_REG;
    end else begin
      illegal_d = 1'b1;
    end
    if (illegal_d) begin
      cls_d   = shift_logic_pkg::OP_NONE;
      clk_d   = 4'h0;
      mem_d   = 1'b0;
      modrm_d = 1'b0;
      imm_d   = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Decode result registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DECODE_VALID_O <= 1'b0;
      ILLEGAL_O      <= 1'b0;
      OP_CLASS_O     <= 4'h0;
      SHIFT_OP_O     <= 3'h0;
      COUNT_SRC_O    <= 2'h0;
      IMM_COUNT_O    <= 8'h00;
      FULL_WIDTH_O   <= 1'b0;
      REG_IS_DEST_O  <= 1'b0;
      MEM_OPERAND_O  <= 1'b0;
      ACCUM_DEST_O   <= 1'b0;
      FLAGS_ONLY_O   <= 1'b0;
      HAS_MODRM_O    <= 1'b0;
      HAS_IMM_O      <= 1'b0;
      CLOCKS_O       <= 4'h0;
    end else begin
      if (take) begin
        DECODE_VALID_O <= 1'b1;
        ILLEGAL_O      <= illegal_d;
        OP_CLASS_O     <= cls_d;
        SHIFT_OP_O     <= (cls_d == shift_logic_pkg::OP_SHIFT) ? sop_d : 3'h0;
        COUNT_SRC_O    <= cnt_d;
        IMM_COUNT_O    <= (cnt_d == shift_logic_pkg::CNT_IMM) ? IMM8_I : 8'h01;
        FULL_WIDTH_O   <= (OPCODE0_I == `OPC_ESCAPE) ? 1'b1 : OPCODE0_I[0]; // see [RQ14]
        REG_IS_DEST_O  <= reg_dest_d;
        MEM_OPERAND_O  <= mem_d;
        ACCUM_DEST_O   <= acc_d;
        FLAGS_ONLY_O   <= flags_d;
        HAS_MODRM_O    <= modrm_d;
        HAS_IMM_O      <= imm_d;
        CLOCKS_O       <= clk_d;
      end else if (DECODE_VALID_O && (ILLEGAL_O || DONE_O)) begin
        DECODE_VALID_O <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Execution timing
  // ------------------------------------------------------------
  clock_counter clock_counter_inst (
    .clk_i   (CLK_I),
    .rst_i   (SYS_RST_I),
    .load_i  (take && !illegal_d),
    .count_i (clk_d),
    .busy_o  (busy),
    .done_o  (tmr_done)
  );

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      DONE_O  <= 1'b0;
      READY_O <= 1'b0;
    end else begin
      DONE_O  <= tmr_done;
      READY_O <= !busy && !take && !(DECODE_VALID_O && !(ILLEGAL_O || DONE_O));
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_rc_clocks: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ4]
    take && !illegal_d && cls_d == shift_logic_pkg::OP_SHIFT && sop_d[2:1] == 2'h1
    |=> CLOCKS_O == (MEM_OPERAND_O ? `CLK_RC_MEM : `CLK_RC_REG))
    else $error("Carry rotate clock count wrong");
  a_shift_clocks: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ2]
    take && OPCODE0_I[7:1] == `OPC_SHIFT_CNT && !sop_d[1] && !illegal_d
    |=> CLOCKS_O == (MEM_OPERAND_O ? 4'h7 : 4'h3) && COUNT_SRC_O == 2'h1)
    else $error("Count register shift decode wrong");
  a_imm_shift: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ3]
    take && OPCODE0_I[7:1] == `OPC_SHIFT_IMM && sop_d != shift_logic_pkg::SHIFT_OP_RESERVED
    |=> COUNT_SRC_O == 2'h2 && IMM_COUNT_O == $past(IMM8_I))
    else $error("Immediate shift count not captured");
  a_double_shift: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ5]
    take && OPCODE0_I == `OPC_ESCAPE && OPCODE1_I == `OPC2_DSHL_CNT
    |=> OP_CLASS_O == 4'h2 && COUNT_SRC_O == 2'h1 && CLOCKS_O == (MEM_OPERAND_O ? 4'h7 : 4'h3))
    else $error("Double left shift decode wrong");
  a_dshr_decode: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ6]
    take && OPCODE0_I == `OPC_ESCAPE && OPCODE1_I == `OPC2_DSHR_IMM
    |=> OP_CLASS_O == 4'h3 && HAS_IMM_O)
    else $error("Double right shift decode wrong");
  a_and_mem: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ8]
    take && OPCODE0_I[7:1] == `OPC_AND_RM && MODRM_I[7:6] != `MOD_REGISTER
    |=> CLOCKS_O == 4'h7 && !REG_IS_DEST_O && MEM_OPERAND_O)
    else $error("AND to memory decode wrong");
  a_and_reg_mem: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ9]
    take && OPCODE0_I[7:1] == `OPC_AND_MR && MODRM_I[7:6] != `MOD_REGISTER
    |=> CLOCKS_O == 4'h6 && REG_IS_DEST_O && MEM_OPERAND_O)
    else $error("AND from memory decode wrong");
  a_test_flags: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ12]
    take && OPCODE0_I[7:1] == `OPC_TEST_RM |=> FLAGS_ONLY_O && CLOCKS_O == (MEM_OPERAND_O ? 4'h5 : 4'h2))
    else $error("Test decode wrong");
  a_acc_form: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ11]
    take && OPCODE0_I[7:1] == `OPC_AND_ACC |=> ACCUM_DEST_O && !HAS_MODRM_O && CLOCKS_O == 4'h2)
    else $error("Accumulator AND decode wrong");
  a_done_timing: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ7]
    take && OPCODE0_I[7:2] == `OPC_AND_RR && MODRM_I[7:6] == `MOD_REGISTER
    |=> !DONE_O ##1 !DONE_O ##1 !DONE_O ##1 DONE_O)
    else $error("Register AND not done after 2 clocks");

  // ------------------------------------------------------------
  // Field and format checks
  // ------------------------------------------------------------
  a_sar_code: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ1]
    take && OPCODE0_I[7:1] == `OPC_SHIFT_ONE && MODRM_I[5:3] == 3'h7
    |=> SHIFT_OP_O == 3'h7 && !ILLEGAL_O && OP_CLASS_O == 4'h1)
    else $error("Arithmetic right shift code wrong");
  a_reserved_op: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ1]
    take && OPCODE0_I[7:1] == `OPC_SHIFT_CNT && MODRM_I[5:3] == 3'h6
    |=> ILLEGAL_O && OP_CLASS_O == 4'h0 && CLOCKS_O == 4'h0)
    else $error("Reserved shift field not refused");
  a_illegal_clear: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ1]
    DECODE_VALID_O && ILLEGAL_O
    |=> !DECODE_VALID_O && !DONE_O)
    else $error("Refused opcode held or timed");
  a_dshl_imm: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ5]
    take && OPCODE0_I == `OPC_ESCAPE && OPCODE1_I == `OPC2_DSHL_IMM
    |=> OP_CLASS_O == 4'h2 && COUNT_SRC_O == 2'h2 && IMM_COUNT_O == $past(IMM8_I))
    else $error("Double left shift immediate wrong");
  a_dshr_cnt: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ6]
    take && OPCODE0_I == `OPC_ESCAPE && OPCODE1_I == `OPC2_DSHR_CNT
    |=> OP_CLASS_O == 4'h3 && COUNT_SRC_O == 2'h1 && CLOCKS_O == (MEM_OPERAND_O ? 4'h7 : 4'h3))
    else $error("Double right shift by count wrong");
  a_and_rr_clocks: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ7]
    take && OPCODE0_I[7:2] == `OPC_AND_RR && MODRM_I[7:6] == `MOD_REGISTER
    |=> OP_CLASS_O == 4'h4 && CLOCKS_O == 4'h2 && !MEM_OPERAND_O)
    else $error("Register AND decode wrong");
  a_imm_and: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ10]
    take && OPCODE0_I[7:1] == `OPC_GRP_IMM && MODRM_I[5:3] == `REG_AND_IMM
    |=> OP_CLASS_O == 4'h4 && HAS_IMM_O && CLOCKS_O == (MEM_OPERAND_O ? 4'h7 : 4'h2))
    else $error("Immediate AND decode wrong");
  a_test_imm: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ13]
    take && OPCODE0_I[7:1] == `OPC_GRP_UNARY && MODRM_I[5:3] == `REG_TEST_IMM
    |=> FLAGS_ONLY_O && HAS_IMM_O && CLOCKS_O == (MEM_OPERAND_O ? 4'h5 : 4'h2))
    else $error("Immediate test decode wrong");
  a_byte_width: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ14]
    take && OPCODE0_I != `OPC_ESCAPE && !OPCODE0_I[0]
    |=> !FULL_WIDTH_O)
    else $error("Byte operand size not decoded");
  a_full_width: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ14]
    take && OPCODE0_I[0]
    |=> FULL_WIDTH_O)
    else $error("Full operand size not decoded");
  a_dir_dest: assert property (@(posedge CLK_I) disable iff (SYS_RST_I) // see [RQ15]
    take && OPCODE0_I[7:2] == `OPC_AND_RR && MODRM_I[7:6] == `MOD_REGISTER && OPCODE0_I[1]
    |=> REG_IS_DEST_O)
    else $error("Direction bit not decoded");

endmodule

//--- testbench/shift_rotate_logic_decode_tb.sv
// Self-checking bench for the shift/rotate/AND/test decoder
// Assumes shift_logic_pkg and the design files are compiled first
`timescale 1ns/10ps
module shift_rotate_logic_decode_tb;
  typedef struct packed {
    logic       ill;
    logic [3:0] cls;
    logic [1:0] csrc;
    logic [7:0] icnt;
    logic       full, rdest, mem, acc, flg, hm, hi;
    logic [3:0] clks;
  } exp_type;

  logic       clk, rst, vld;
  logic [7:0] op0, op1, modrm, imm;
  logic       ready, dvalid, ill, full, rdest, mem, acc, flg, hm, hi, done;
  logic [3:0] cls, clks;
  logic [2:0] sop;
  logic [1:0] csrc;
  logic [7:0] icnt;
  int         error_cnt, n_checks, cycles;
  logic [7:0] lst[20] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1, 8'h0F, 8'h20, 8'h21, 8'h22,
                          8'h23, 8'h80, 8'h81, 8'h24, 8'h25, 8'h84, 8'h85, 8'hF6, 8'hF7, 8'h30};
  logic [7:0] dsh[4] = '{8'hA4, 8'hA5, 8'hAC, 8'hAD};

  shift_rotate_logic_decode shift_rotate_logic_decode_inst (
    .CLK_I(clk), .SYS_RST_I(rst), .INSN_VALID_I(vld), .OPCODE0_I(op0), .OPCODE1_I(op1),
    .MODRM_I(modrm), .IMM8_I(imm), .READY_O(ready), .DECODE_VALID_O(dvalid), .ILLEGAL_O(ill),
    .OP_CLASS_O(cls), .SHIFT_OP_O(sop), .COUNT_SRC_O(csrc), .IMM_COUNT_O(icnt),
    .FULL_WIDTH_O(full), .REG_IS_DEST_O(rdest), .MEM_OPERAND_O(mem), .ACCUM_DEST_O(acc),
    .FLAGS_ONLY_O(flg), .HAS_MODRM_O(hm), .HAS_IMM_O(hi), .CLOCKS_O(clks), .DONE_O(done));

  // ----------------------------------------
  // Expected decode
  // ----------------------------------------
  function automatic exp_type exp_of(logic [7:0] o0, logic [7:0] o1, logic [7:0] m, logic [7:0] i8);
    exp_type e;
    logic    mm;
    e = '0;
    mm = (m[7:6] != 2'h3);
    e.mem = mm;
    e.full = o0[0];
    e.hm = 1'b1;
    e.icnt = 8'h01;
    e.cls = shift_logic_pkg::OP_AND;
    if (o0 == 8'h0F) begin
      e.full = 1'b1;
      e.cls = o1[3] ? shift_logic_pkg::OP_DOUBLE_RIGHT : shift_logic_pkg::OP_DOUBLE_LEFT;
      e.hi = ~o1[0];
      e.csrc = o1[0] ? shift_logic_pkg::CNT_REG : shift_logic_pkg::CNT_IMM;
      if (!o1[0]) e.icnt = i8;
      e.clks = mm ? 4'h7 : 4'h3;
      e.ill = !(o1 inside {8'hA4, 8'hA5, 8'hAC, 8'hAD});
    end else if (o0[7:1] inside {7'h68, 7'h69, 7'h60}) begin
      e.cls = shift_logic_pkg::OP_SHIFT;
      e.ill = (m[5:3] == 3'h6);
      e.hi = (o0[7:1] == 7'h60);
      e.csrc = e.hi ? shift_logic_pkg::CNT_IMM : (o0[1] ? shift_logic_pkg::CNT_REG : shift_logic_pkg::CNT_ONE);
      if (e.hi) e.icnt = i8;
      if (m[5:4] == 2'h1) e.clks = mm ? 4'hA : 4'h9;
      else e.clks = mm ? 4'h7 : 4'h3;
    end else if (o0[7:2] == 6'h08) begin
      e.rdest = o0[1];
      e.clks = mm ? (o0[1] ? 4'h6 : 4'h7) : 4'h2;
    end else if (o0[7:1] == 7'h40) begin
      e.ill = (m[5:3] != 3'h4);
      e.hi = 1'b1;
      e.clks = mm ? 4'h7 : 4'h2;
    end else if (o0[7:1] == 7'h12) begin
      e.acc = 1'b1;
      e.mem = 1'b0;
      e.hm = 1'b0;
      e.hi = 1'b1;
      e.clks = 4'h2;
    end else if (o0[7:1] inside {7'h42, 7'h7B}) begin
      e.cls = shift_logic_pkg::OP_TEST;
      e.flg = 1'b1;
      e.hi = o0[1];
      e.ill = o0[1] && (m[5:3] != 3'h0);
      e.clks = mm ? 4'h5 : 4'h2;
    end else e.ill = 1'b1;
    return e;
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Offer one instruction at a falling edge and follow it to the end
  task automatic run(logic [7:0] o0, logic [7:0] o1, logic [7:0] m, logic [7:0] i8);
    exp_type e;
    int      k;
    logic    dn;
    e = exp_of(o0, o1, m, i8);
    op0 = o0;
    op1 = o1;
    modrm = m;
    imm = i8;
    vld = 1'b1;
    k = 0;
    while (dvalid !== 1'b1 && k < 20) begin
      @(negedge clk);
      k++;
    end
    check("latency", 8'(k), 8'h01);
    check("illegal", ill, e.ill);
    if (e.ill) vld = 1'b0;
    op0 = 8'($urandom);
    modrm = 8'($urandom);
    if (!e.ill) begin
      check("class", cls, e.cls);
      check("clocks", clks, e.clks);
      check("width", full, e.full);
      check("flags", flg, e.flg);
      check("accum", acc, e.acc);
      check("has imm", hi, e.hi);
      check("has modrm", hm, e.hm);
      check("mem", mem, e.mem);
      check("imm count", icnt, e.icnt);
      check("reg dest", rdest, e.rdest);
      if (e.cls == shift_logic_pkg::OP_SHIFT) begin
        check("shift op", sop, m[5:3]);
        check("count src", csrc, e.csrc);
      end
      if (e.cls != shift_logic_pkg::OP_SHIFT && e.csrc != 2'h0) check("dbl src", csrc, e.csrc);
      k = 0;
      while (done !== 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
      end
      // Done shows one cycle after the decode cycle plus the count
      check("exec clocks", 8'(k), 8'(e.clks) + 8'h01);
      check("stand class", cls, e.cls);
      vld = 1'b0;
      @(negedge clk);
      check("done pulse", done, 1'b0);
    end else begin
      dn = 1'b0;
      k = 0;
      while (dvalid === 1'b1 && k < 20) begin
        @(negedge clk);
        k++;
        dn = dn | done;
      end
      check("no done", dn, 1'b0);
    end
    check("valid fall", dvalid, 1'b0);
    check("ready", ready, 1'b1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    vld = 1'b0;
    op0 = 8'h00;
    op1 = 8'h00;
    modrm = 8'h00;
    imm = 8'h00;
    void'($urandom(82));
    repeat (8) @(negedge clk);
    rst = 1'b0;
    check("reset valid", dvalid, 1'b0);
    for (int i = 0; i < 20; i++) begin
      for (int j = 0; j < 8; j++) begin
        run(lst[i], dsh[j % 4], {((i + j) % 2 == 1) ? 2'h3 : 2'h0, 3'(j), 3'h2}, 8'h1F);
      end
    end
    $display("test directed done, errors %0d", error_cnt);
    // Reset in the middle of a long rotate
    op0 = 8'hD2;
    modrm = 8'h10;
    vld = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b1;
    vld = 1'b0;
    @(negedge clk);
    check("rst valid", dvalid, 1'b0);
    check("rst done", done, 1'b0);
    rst = 1'b0;
    run(8'hD3, 8'h00, 8'hD8, 8'h00);
    $display("test reset done, errors %0d", error_cnt);
    for (int r = 0; r < 300; r++) begin
      run(($urandom % 4 == 0) ? 8'($urandom) : lst[$urandom % 20],
          ($urandom % 4 == 0) ? 8'($urandom) : dsh[$urandom % 4], 8'($urandom), 8'($urandom));
    end
    $display("test random done, errors %0d", error_cnt);
    report_and_stop();
  end
endmodule
